// ==== hdl/gdc_defs.svh ====
`ifndef GDC_DEFS_SVH
`define GDC_DEFS_SVH

`define GDC_ADDR_W          7
`define GDC_STORE_TOP       7'h1c
`define GDC_STORE_W         29
`define GDC_STORE_MASK      29'h1f3f_ffff
`define GDC_STATUS_BASE     7'h1d
`define GDC_STATUS_TOP      7'h27
`define GDC_STATUS_W        11
`define GDC_STATUS_W1C_MASK 11'h037
`define GDC_STATUS_RD_MASK  11'h7f7

`define GDC_TRIM_LSB        0
`define GDC_TRIM_W          14
`define GDC_SC_DISABLE_BIT  14
`define GDC_BEMF_SEL_BIT    15
`define GDC_SOURCE_LSB      16
`define GDC_SINK_LSB        19
`define GDC_TEST_LSB        24
`define GDC_TEST_W          5

`define GDC_ST_LS_LSB       0
`define GDC_ST_HS_LSB       4
`define GDC_ST_LIVE_LSB     6

`define GDC_REMAP_KEY       8'h67

`define GDC_PEAK_CODE0      10'h3e8
`define GDC_PEAK_CODE1      10'h190
`define GDC_PEAK_CODE2      10'h12c
`define GDC_PEAK_CODE3      10'h0c8
`define GDC_PEAK_CODE4      10'h096
`define GDC_PEAK_CODE5      10'h07d
`define GDC_PEAK_CODE6      10'h064
`define GDC_PEAK_CODE7      10'h04b

`endif

// ==== hdl/gdc_pkg.sv ====
package gdc_pkg;

  typedef logic [2:0] gdc_drive_code_t;
  typedef logic [9:0] gdc_peak_ma_t;
  typedef logic [6:0] gdc_bit_addr_t;

  typedef enum logic {
    GDC_BEMF_RATIO_12,
    GDC_BEMF_RATIO_5
  } gdc_bemf_ratio_t;

endpackage : gdc_pkg

// ==== hdl/gdc_bit_store.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "gdc_defs.svh"

module gdc_bit_store #(
  parameter int               W    = `GDC_STORE_W,
  parameter logic [W-1:0]     MASK = `GDC_STORE_MASK
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rstn,
  input  wire logic                  i_wr_en,
  input  wire gdc_pkg::gdc_bit_addr_t i_addr,
  input  wire logic                  i_wdata,
  output logic [W-1:0]               o_bits,
  output logic                       o_rdata
);

  logic [W-1:0] next_bits;
  logic         next_rdata;

  // Bits outside the mask hold zero and ignore writes.
  always_comb begin
    next_bits  = o_bits;
    next_rdata = 1'b0;
    if (i_wr_en && (i_addr < 7'(W))) begin
      next_bits[i_addr[4:0]] = i_wdata & MASK[i_addr[4:0]];
    end
    if (i_addr < 7'(W)) begin
      next_rdata = o_bits[i_addr[4:0]];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_bits  <= '0;
      o_rdata <= 1'b0;
    end else begin
      o_bits  <= next_bits;
      o_rdata <= next_rdata;
    end
  end

endmodule : gdc_bit_store

`default_nettype wire

// ==== hdl/gdc_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "gdc_defs.svh"

module gdc_regs (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rstn,
  input  wire logic                     i_acc_valid,
  input  wire logic                     i_acc_write,
  input  wire gdc_pkg::gdc_bit_addr_t   i_acc_addr,
  input  wire logic                     i_acc_wdata,
  output logic                          o_acc_rvalid,
  output logic                          o_acc_rdata,
  input  wire logic                     i_remap_wr,
  input  wire logic [7:0]               i_remap_wdata,
  output logic                          o_remap,
  input  wire logic [2:0]               i_pwm_lo,
  input  wire logic [2:0]               i_pwm_hi,
  output logic [5:0]                    o_gpio_pwm,
  output logic [2:0]                    o_top_gate_drive,
  output logic [2:0]                    o_bottom_gate_drive,
  input  wire logic [2:0]               i_lower_switch_short,
  input  wire logic [1:0]               i_upper_switch_short,
  input  wire logic                     i_over_temp,
  input  wire logic                     i_charge_pump_good,
  input  wire logic                     i_motor_supply_undervolt,
  input  wire logic                     i_logic_supply_undervolt,
  input  wire logic                     i_driver_not_ready,
  output logic [`GDC_TRIM_W-1:0]        o_analog_trim,
  output logic                          o_sc_protect_off,
  output gdc_pkg::gdc_bemf_ratio_t      o_bemf_ratio,
  output gdc_pkg::gdc_drive_code_t      o_source_code,
  output gdc_pkg::gdc_drive_code_t      o_sink_code,
  output gdc_pkg::gdc_peak_ma_t         o_source_peak_ma,
  output gdc_pkg::gdc_peak_ma_t         o_sink_peak_ma,
  output logic [`GDC_TEST_W-1:0]        o_test_select
);

  function automatic gdc_pkg::gdc_peak_ma_t peak_ma(input gdc_pkg::gdc_drive_code_t code);
    case (code)
      3'h0:    peak_ma = `GDC_PEAK_CODE0;
      3'h1:    peak_ma = `GDC_PEAK_CODE1;
      3'h2:    peak_ma = `GDC_PEAK_CODE2;
      3'h3:    peak_ma = `GDC_PEAK_CODE3;
      3'h4:    peak_ma = `GDC_PEAK_CODE4;
      3'h5:    peak_ma = `GDC_PEAK_CODE5;
      3'h6:    peak_ma = `GDC_PEAK_CODE6;
      default: peak_ma = `GDC_PEAK_CODE7;
    endcase
  endfunction : peak_ma

  // Writable configuration bits live in the bit store.
  logic [`GDC_STORE_W-1:0] store_bits;
  logic                    store_rdata;
  logic                    store_wr;

  assign store_wr = i_acc_valid & i_acc_write & (i_acc_addr <= `GDC_STORE_TOP);

  gdc_bit_store #(
    .W    (`GDC_STORE_W),
    .MASK (`GDC_STORE_MASK)
  ) u_store (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_wr_en   (store_wr),
    .i_addr    (i_acc_addr),
    .i_wdata   (i_acc_wdata),
    .o_bits    (store_bits),
    .o_rdata   (store_rdata)
  );

  // Decoded configuration outputs, registered.
  logic [`GDC_TRIM_W-1:0]   next_trim;
  gdc_pkg::gdc_drive_code_t next_src;
  gdc_pkg::gdc_drive_code_t next_snk;

  always_comb begin
    next_trim = store_bits[`GDC_TRIM_LSB +: `GDC_TRIM_W];
    next_src  = store_bits[`GDC_SOURCE_LSB +: 3];
    next_snk  = store_bits[`GDC_SINK_LSB +: 3];
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_analog_trim    <= '0;
      o_sc_protect_off <= 1'b0;
      o_bemf_ratio     <= gdc_pkg::GDC_BEMF_RATIO_12;
      o_source_code    <= '0;
      o_sink_code      <= '0;
      o_source_peak_ma <= `GDC_PEAK_CODE0;
      o_sink_peak_ma   <= `GDC_PEAK_CODE0;
      o_test_select    <= '0;
    end else begin
      o_analog_trim    <= next_trim;
      o_sc_protect_off <= store_bits[`GDC_SC_DISABLE_BIT];
      o_bemf_ratio     <= gdc_pkg::gdc_bemf_ratio_t'(store_bits[`GDC_BEMF_SEL_BIT]);
      o_source_code    <= next_src;
      o_sink_code      <= next_snk;
      o_source_peak_ma <= peak_ma(next_src);
      o_sink_peak_ma   <= peak_ma(next_snk);
      o_test_select    <= store_bits[`GDC_TEST_LSB +: `GDC_TEST_W];
    end
  end

  // Analogue detector levels pass two flip-flops before use.
  logic [9:0] det_meta;
  logic [9:0] det_sync;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      det_meta <= '0;
      det_sync <= '0;
    end else begin
      det_meta <= {i_driver_not_ready, i_logic_supply_undervolt, i_motor_supply_undervolt,
                   i_charge_pump_good, i_over_temp, i_upper_switch_short,
                   i_lower_switch_short};
      det_sync <= det_meta;
    end
  end

  // Status flags: sticky short-circuit bits and live condition bits.
  logic [`GDC_STATUS_W-1:0] status;
  logic [`GDC_STATUS_W-1:0] next_status;
  logic [`GDC_STATUS_W-1:0] w1c_hit;
  logic [`GDC_STATUS_W-1:0] sc_set;
  gdc_pkg::gdc_bit_addr_t   st_off;

  always_comb begin
    st_off  = 7'(i_acc_addr - `GDC_STATUS_BASE);
    w1c_hit = '0;
    if (i_acc_valid && i_acc_write && i_acc_wdata &&
        (i_acc_addr >= `GDC_STATUS_BASE) && (i_acc_addr <= `GDC_STATUS_TOP)) begin
      w1c_hit[st_off[3:0]] = 1'b1;
    end
    w1c_hit = w1c_hit & `GDC_STATUS_W1C_MASK;
    sc_set  = '0;
    if (!o_sc_protect_off) begin
      sc_set[`GDC_ST_LS_LSB +: 3] = det_sync[2:0];
      sc_set[`GDC_ST_HS_LSB +: 2] = det_sync[4:3];
    end
    // A detection in the clearing cycle wins over the clear.
    next_status = ((status & ~w1c_hit) | sc_set) & `GDC_STATUS_W1C_MASK;
    next_status[`GDC_ST_LIVE_LSB +: 5] = det_sync[9:5];
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // Read path: request, then status bit and store bit, then answer.
  localparam logic [`GDC_STATUS_W-1:0] RD_MASK = `GDC_STATUS_RD_MASK;

  logic rd_pend;
  logic rd_is_status;
  logic rd_status_bit;
  logic next_rd_status_bit;

  always_comb begin
    next_rd_status_bit = 1'b0;
    if ((i_acc_addr >= `GDC_STATUS_BASE) && (i_acc_addr <= `GDC_STATUS_TOP)) begin
      next_rd_status_bit = status[st_off[3:0]] & RD_MASK[st_off[3:0]];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rd_pend       <= 1'b0;
      rd_is_status  <= 1'b0;
      rd_status_bit <= 1'b0;
      o_acc_rvalid  <= 1'b0;
      o_acc_rdata   <= 1'b0;
    end else begin
      rd_pend       <= i_acc_valid & ~i_acc_write;
      rd_is_status  <= i_acc_addr > `GDC_STORE_TOP;
      rd_status_bit <= next_rd_status_bit;
      o_acc_rvalid  <= rd_pend;
      o_acc_rdata   <= rd_pend & (rd_is_status ? rd_status_bit : store_rdata);
    end
  end

  // Keyed remap register on the PWM side.
  logic next_remap;

  always_comb begin
    next_remap = o_remap;
    if (i_remap_wr) begin
      next_remap = (i_remap_wdata == `GDC_REMAP_KEY);
    end
  end

  // PWM pins and gate drive, one phase per loop pass.
  logic [5:0] next_pins;
  logic [2:0] next_top;
  logic [2:0] next_bot;
  logic       sc_block;

  assign sc_block = |status[`GDC_ST_LS_LSB +: 6] & ~o_sc_protect_off;

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      always_comb begin
        if (o_remap) begin
          next_pins[ph]     = i_pwm_lo[ph];
          next_pins[ph + 3] = i_pwm_hi[ph];
        end else begin
          next_pins[ph]     = (ph == 0) ? i_pwm_hi[0] : (ph == 1) ? i_pwm_lo[0] : i_pwm_hi[1];
          next_pins[ph + 3] = (ph == 0) ? i_pwm_lo[1] : (ph == 1) ? i_pwm_hi[2] : i_pwm_lo[2];
        end
        next_top[ph] = o_gpio_pwm[ph + 3] & ~o_gpio_pwm[ph] & ~sc_block;
        next_bot[ph] = o_gpio_pwm[ph] & ~o_gpio_pwm[ph + 3] & ~sc_block;
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_remap             <= 1'b0;
      o_gpio_pwm          <= '0;
      o_top_gate_drive    <= '0;
      o_bottom_gate_drive <= '0;
    end else begin
      o_remap             <= next_remap;
      o_gpio_pwm          <= next_pins;
      o_top_gate_drive    <= next_top;
      o_bottom_gate_drive <= next_bot;
    end
  end

  a_remap_key_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_remap_wr && (i_remap_wdata == 8'h67) |=> o_remap)
    else $error("remap bit not set by key write");

  a_remap_other_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_remap_wr && (i_remap_wdata != 8'h67) |=> !o_remap)
    else $error("remap bit not cleared by other value");

  a_shoot_through_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_remap_wr == 1'b0 && o_remap && (i_pwm_lo[0] && i_pwm_hi[0])
    |=> ##1 !o_top_gate_drive[0] && !o_bottom_gate_drive[0])
    else $error("both gates of phase 1 driven on pattern 11");

  a_lower_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_gpio_pwm[1] && !o_gpio_pwm[4] && !sc_block
    |=> o_bottom_gate_drive[1] && !o_top_gate_drive[1])
    else $error("lower gate of phase 2 does not follow its input");

  a_remap_route: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_remap && !i_remap_wr |=> o_gpio_pwm == {$past(i_pwm_hi), $past(i_pwm_lo)})
    else $error("remapped pin order wrong");

  a_sc_sticky_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    status[0] && !(i_acc_valid && i_acc_write && i_acc_wdata && i_acc_addr == 7'h1d)
    |=> status[0])
    else $error("lower short flag U lost without clear");

  a_sc_disable_mask: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $rose(status[4]) |-> !$past(o_sc_protect_off))
    else $error("upper short flag set while protection off");

  a_peak_map: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_source_code == 3'h0 |-> o_source_peak_ma == 10'h3e8)
    else $error("source code 0 not mapped to 1000 mA");

  a_unmapped_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_acc_valid && !i_acc_write && i_acc_addr > 7'h27 |-> ##2 o_acc_rvalid && !o_acc_rdata)
    else $error("unmapped address read nonzero");

  a_ready_live: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ##3 $past(i_driver_not_ready, 3) == status[10])
    else $error("not ready flag does not track its detector");

  a_read_latency: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_acc_valid && !i_acc_write |-> ##2 o_acc_rvalid)
    else $error("read answer missing two cycles after request");

  a_rvalid_cause: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_acc_rvalid |-> $past(i_acc_valid && !i_acc_write, 2))
    else $error("read answer without a read request");

  a_sc_set_wins: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    det_sync[0] && !o_sc_protect_off |=> status[0])
    else $error("lower short flag U not set on detection");

endmodule : gdc_regs

`default_nettype wire

// ==== dv/gdc_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module gdc_host_model (
  input  wire logic              i_ref_clk,
  input  wire logic              i_acc_rvalid,
  input  wire logic              i_acc_rdata,
  output logic                   o_acc_valid,
  output logic                   o_acc_write,
  output gdc_pkg::gdc_bit_addr_t o_acc_addr,
  output logic                   o_acc_wdata,
  output logic                   o_remap_wr,
  output logic [7:0]             o_remap_wdata,
  output logic [2:0]             o_pwm_lo,
  output logic [2:0]             o_pwm_hi
);
  logic remap_done;

  initial begin
    o_acc_valid   = 1'b0;
    o_acc_write   = 1'b0;
    o_acc_addr    = 7'h7f;
    o_acc_wdata   = 1'b0;
    o_remap_wr    = 1'b0;
    o_remap_wdata = 8'h00;
    o_pwm_lo      = 3'h0;
    o_pwm_hi      = 3'h0;
    remap_done    = 1'b0;
  end

  // Idle qualifiers show the inverse so a stale value is never read as valid.
  task automatic access(input logic wr, input gdc_pkg::gdc_bit_addr_t a, input logic d);
    @(negedge i_ref_clk);
    o_acc_valid = 1'b1;
    o_acc_write = wr;
    o_acc_addr  = a;
    o_acc_wdata = d;
    @(negedge i_ref_clk);
    o_acc_valid = 1'b0;
    o_acc_write = ~wr;
    o_acc_addr  = ~a;
    o_acc_wdata = ~d;
  endtask : access

  task automatic wr_bit(input gdc_pkg::gdc_bit_addr_t a, input logic d);
    access(1'b1, a, d);
  endtask : wr_bit

  task automatic rd_bit(input gdc_pkg::gdc_bit_addr_t a, output logic d);
    d = 1'bx;
    access(1'b0, a, 1'b0);
    repeat (3) begin
      @(negedge i_ref_clk);
      if (i_acc_rvalid === 1'b1) begin
        d = i_acc_rdata;
      end
    end
  endtask : rd_bit

  task automatic wr_remap(input logic [7:0] v);
    @(negedge i_ref_clk);
    o_remap_wr    = 1'b1;
    o_remap_wdata = v;
    @(negedge i_ref_clk);
    o_remap_wr    = 1'b0;
    o_remap_wdata = ~v;
    remap_done    = (v == 8'h67);
  endtask : wr_remap

  // PWM stays quiet until the remap has been enabled.
  task automatic set_pwm(input logic [2:0] lo, input logic [2:0] hi);
    @(negedge i_ref_clk);
    o_pwm_lo = remap_done ? lo : 3'h0;
    o_pwm_hi = remap_done ? hi : 3'h0;
  endtask : set_pwm
endmodule : gdc_host_model

`default_nettype wire

// ==== dv/gdc_regs_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module gdc_regs_tb;
  logic                     i_ref_clk;
  logic                     i_rstn;
  logic                     acc_valid, acc_write, acc_wdata, rvalid, rdata;
  gdc_pkg::gdc_bit_addr_t   acc_addr;
  logic                     remap_wr, remap;
  logic [7:0]               remap_wdata;
  logic [2:0]               pwm_lo, pwm_hi, top, bot, src, snk, ls_short;
  logic [5:0]               gpio;
  logic [1:0]               hs_short;
  logic [4:0]               live, tsel;
  logic [13:0]              trim;
  logic                     sc_off;
  gdc_pkg::gdc_bemf_ratio_t bemf;
  gdc_pkg::gdc_peak_ma_t    src_ma, snk_ma;
  int                       n_errors, num_checks, cyc;
  logic [9:0]               peak [8] = '{10'h3e8, 10'h190, 10'h12c, 10'h0c8,
                                         10'h096, 10'h07d, 10'h064, 10'h04b};
  localparam logic [28:0]   PAT = 29'h15b6_c5a9;

  gdc_host_model gdc_host_model_inst (.i_ref_clk(i_ref_clk), .i_acc_rvalid(rvalid),
    .i_acc_rdata(rdata), .o_acc_valid(acc_valid), .o_acc_write(acc_write),
    .o_acc_addr(acc_addr), .o_acc_wdata(acc_wdata), .o_remap_wr(remap_wr),
    .o_remap_wdata(remap_wdata), .o_pwm_lo(pwm_lo), .o_pwm_hi(pwm_hi));

  gdc_regs gdc_regs_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_acc_valid(acc_valid),
    .i_acc_write(acc_write), .i_acc_addr(acc_addr), .i_acc_wdata(acc_wdata),
    .o_acc_rvalid(rvalid), .o_acc_rdata(rdata), .i_remap_wr(remap_wr),
    .i_remap_wdata(remap_wdata), .o_remap(remap), .i_pwm_lo(pwm_lo), .i_pwm_hi(pwm_hi),
    .o_gpio_pwm(gpio), .o_top_gate_drive(top), .o_bottom_gate_drive(bot),
    .i_lower_switch_short(ls_short), .i_upper_switch_short(hs_short),
    .i_over_temp(live[0]), .i_charge_pump_good(live[1]), .i_motor_supply_undervolt(live[2]),
    .i_logic_supply_undervolt(live[3]), .i_driver_not_ready(live[4]),
    .o_analog_trim(trim), .o_sc_protect_off(sc_off), .o_bemf_ratio(bemf),
    .o_source_code(src), .o_sink_code(snk), .o_source_peak_ma(src_ma),
    .o_sink_peak_ma(snk_ma), .o_test_select(tsel));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic t_reset();
    logic d;
    check(src_ma, 10'h3e8);
    check(sc_off, 1'b0);
    check(bemf, gdc_pkg::GDC_BEMF_RATIO_12);
    for (int a = 0; a < 48; a++) begin
      gdc_host_model_inst.rd_bit(a[6:0], d);
      check(d, 1'b0);
    end
  endtask : t_reset

  task automatic t_fields();
    logic d;
    for (int a = 0; a < 29; a++) gdc_host_model_inst.wr_bit(a[6:0], PAT[a]);
    repeat (3) @(negedge i_ref_clk);
    check(trim, PAT[13:0]);
    check(sc_off, 1'b1);
    check(bemf, gdc_pkg::GDC_BEMF_RATIO_5);
    check(src, PAT[18:16]);
    check(snk, PAT[21:19]);
    check(tsel, PAT[28:24]);
    for (int a = 0; a < 29; a++) begin
      gdc_host_model_inst.rd_bit(a[6:0], d);
      check(d, (a == 22 || a == 23) ? 1'b0 : PAT[a]);
    end
    gdc_host_model_inst.wr_bit(7'h0e, 1'b0);
    repeat (3) @(negedge i_ref_clk);
    check(sc_off, 1'b0);
  endtask : t_fields

  task automatic t_peak();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      for (int b = 0; b < 3; b++) begin
        gdc_host_model_inst.wr_bit(7'(16 + b), c[b]);
        gdc_host_model_inst.wr_bit(7'(19 + b), ~c[b]);
      end
      repeat (3) @(negedge i_ref_clk);
      check(src, c);
      check(snk, 3'(~c));
      check(src_ma, peak[i]);
      check(snk_ma, peak[7 - i]);
    end
  endtask : t_peak

  task automatic t_sticky();
    logic       d;
    logic [5:0] st;
    int         clr [3] = '{29, 31, 34};
    st = 6'b100101;
    ls_short = 3'b101;
    hs_short = 2'b10;
    repeat (3) @(negedge i_ref_clk);
    ls_short = 3'b000;
    hs_short = 2'b00;
    repeat (4) @(negedge i_ref_clk);
    for (int a = 29; a < 35; a++) begin
      gdc_host_model_inst.rd_bit(a[6:0], d);
      check(d, st[a - 29]);
    end
    gdc_host_model_inst.wr_bit(7'h1d, 1'b0);
    gdc_host_model_inst.rd_bit(7'h1d, d);
    check(d, 1'b1);
    gdc_host_model_inst.wr_bit(7'h20, 1'b1);
    gdc_host_model_inst.rd_bit(7'h20, d);
    check(d, 1'b0);
    foreach (clr[k]) begin
      gdc_host_model_inst.wr_bit(clr[k][6:0], 1'b1);
      gdc_host_model_inst.rd_bit(clr[k][6:0], d);
      check(d, 1'b0);
    end
    gdc_host_model_inst.wr_bit(7'h0e, 1'b1);
    ls_short = 3'b001;
    hs_short = 2'b01;
    repeat (3) @(negedge i_ref_clk);
    ls_short = 3'b000;
    hs_short = 2'b00;
    repeat (4) @(negedge i_ref_clk);
    gdc_host_model_inst.rd_bit(7'h1d, d);
    check(d, 1'b0);
    gdc_host_model_inst.rd_bit(7'h21, d);
    check(d, 1'b0);
    gdc_host_model_inst.wr_bit(7'h0e, 1'b0);
  endtask : t_sticky

  task automatic t_live();
    logic d;
    for (int k = 0; k < 5; k++) begin
      live = 5'(1 << k);
      repeat (5) @(negedge i_ref_clk);
      for (int j = 0; j < 5; j++) begin
        gdc_host_model_inst.rd_bit(7'(35 + j), d);
        check(d, j == k);
      end
    end
    live = 5'h00;
    repeat (5) @(negedge i_ref_clk);
    gdc_host_model_inst.rd_bit(7'h27, d);
    check(d, 1'b0);
  endtask : t_live

  task automatic t_pwm();
    logic [2:0] lo, hi;
    check(remap, 1'b0);
    gdc_host_model_inst.wr_remap(8'h67);
    check(remap, 1'b1);
    gdc_host_model_inst.wr_remap(8'h66);
    check(remap, 1'b0);
    gdc_host_model_inst.wr_remap(8'h67);
    for (int v = 0; v < 64; v++) begin
      lo = v[2:0];
      hi = v[5:3];
      gdc_host_model_inst.set_pwm(lo, hi);
      repeat (3) @(negedge i_ref_clk);
      check(gpio, {hi, lo});
      check(bot, lo & ~hi);
      check(top, hi & ~lo);
      check({top, bot}, (lo & hi) == 3'h7 ? 6'h00 : {hi & ~lo, lo & ~hi});
    end
  endtask : t_pwm

  initial begin
    n_errors   = 0;
    num_checks = 0;
    cyc        = 0;
    i_rstn     = 1'b0;
    ls_short   = 3'h0;
    hs_short   = 2'h0;
    live       = 5'h00;
    repeat (10) @(negedge i_ref_clk);
    i_rstn = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    t_reset();
    t_fields();
    t_peak();
    t_sticky();
    t_live();
    t_pwm();
    wrap_up();
  end
endmodule : gdc_regs_tb

`default_nettype wire
